// ==== common/nvm_prog_pkg.sv ====
// Purpose: Shared constants for the memory programming sequencer
// Assumes: 32-bit AXI4-Lite register bus, 4-word blocks
// Notes:   Offsets, field positions, command codes and state codes
package nvm_prog_pkg;

    // ****************************************************************
    // Bus map
    // ****************************************************************
    localparam logic [31:0] SEQ_STATUS_OFFSET = 32'h0000_0000; // Sequencer state, read only
    localparam logic [31:0] PROG_CTRL_OFFSET  = 32'h0000_0004; // programming_control
    localparam int          MEM_SEL_HI        = 31;            // Memory window select field
    localparam int          MEM_SEL_LO        = 16;
    localparam logic [15:0] MEM_SEL_VALUE     = 16'h0001;      // Window at 0x0001_0000
    localparam int          WORD_IDX_HI       = 3;             // Word index inside a block
    localparam int          WORD_IDX_LO       = 2;
    localparam int          BLOCK_WORDS       = 4;
    localparam int          DATA_W            = 32;
    localparam int          BLOCK_W           = BLOCK_WORDS * DATA_W;
    localparam int          ECC_W             = 8;

    // ****************************************************************
    // programming_control fields
    // ****************************************************************
    localparam int VERIFY_HI       = 7;
    localparam int VERIFY_LO       = 6;
    localparam int ONESHOT_HI      = 5;
    localparam int ONESHOT_LO      = 4;
    localparam int OPERATION_TYPE_HI       = 3;
    localparam int OPERATION_TYPE_LO       = 0;
    localparam int CLR_VERIFY_ERROR_COUNT_BIT    = 12;
    localparam int CLR_ECC_BIT     = 13;
    localparam logic [7:0] ACTION_RESET = 8'h00;

    // Operation type, one-shot and verify codes
    localparam logic [3:0] OPERATION_TYPE_IDLE   = 4'h0;
    localparam logic [3:0] OPERATION_TYPE_WRITE  = 4'h1;
    localparam logic [3:0] OPERATION_TYPE_ERASE  = 4'h2;
    localparam logic [1:0] ONESHOT_ONCE  = 2'h1;
    localparam logic [1:0] VERIFY_AUTO   = 2'h1;
    localparam logic [1:0] VERIFY_NONE   = 2'h2;
    localparam logic [1:0] VERIFY_ARRAY  = 2'h3;

    // Accepted command values; any other value reads as idle
    localparam logic [7:0] ACT_IDLE      = 8'h00;
    localparam logic [7:0] ACT_WR_ONE_V  = 8'h51;
    localparam logic [7:0] ACT_WR_ONE    = 8'h91;
    localparam logic [7:0] ACT_WR_CONT_V = 8'h61;
    localparam logic [7:0] ACT_WR_CONT   = 8'hA1;
    localparam logic [7:0] ACT_ERASE_ONE = 8'h92;
    localparam logic [7:0] ACT_VFY_ONE   = 8'hD0;
    localparam logic [7:0] ACT_VFY_CONT  = 8'hE0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_LAUNCH = 2'b01,
        SEQ_RUN    = 2'b10
    } seq_state_t;

endpackage

// ==== hdl/ecc_block_gen.sv ====
// Purpose: Check-bit generator for one programming block
// Assumes: Purely combinational, fed from registered block data
// Notes:   Hamming positions over the data plus one overall parity bit
`timescale 1ns/1ps
module ecc_block_gen #(
    parameter int DATA_BITS = 128,
    parameter int CHECK_BITS = 8
) (
    input  wire logic [DATA_BITS-1:0]  data,  // Block data
    output logic      [CHECK_BITS-1:0] check  // Generated check bits
);

    // ****************************************************************
    // Check bit computation
    // ****************************************************************
    // Each check bit below the top one covers the data positions whose 1-based index has its bit set
    always_comb begin
        logic acc;
        acc   = 1'b0;
        check = '0;
        for (int i = 0; i < CHECK_BITS - 1; i++) begin
            acc = 1'b0;
            for (int j = 0; j < DATA_BITS; j++) begin
                if ((((j + 1) >> i) & 1) != 0) begin
                    acc = acc ^ data[j];
                end
            end
            check[i] = acc;
        end
        check[CHECK_BITS-1] = ^data; // Overall parity catches double errors
    end

endmodule

// ==== hdl/nvm_program_action_control.sv ====
// What this block does
// - Command splits into verify, one-shot, type
// - Type 0 idle/verify, 1 write, 2 erase
// - One-shot command returns idle after operation
// - Verify codes: 01 auto, 10 none, 11 array
// - Undefined command reads idle; 00 exits mode
// - 51h arms one-shot write with verify
// - Memory-range write supplies address and starts
// - New command accepted only from idle
// - Same value keeps, different value clears
// - Verify needs full block including ECC
// - Device generates block ECC on write
// - Auto verify uses both hardread levels
// - Array verify samples configured level at start
// - Busy rises only after trigger transfer
// - Completion shown by busy low and interrupt
// - Sleep forces command back to idle
// - Bit 13 clears ECC and protocol flags
// - Bit 12 clears verify error field
// - Reserved bits read zero
// - 61h/A1h continuous write, 00 ends it
// - Writes and memory accesses stall while busy
// - Entering write or verify clears verify errors
//
// Purpose: Arms and launches write, erase and verify operations of the array
// Assumes: Array core and status register live outside, on the same clock
// Notes:   One AXI4-Lite port serves both the registers and the memory window
`timescale 1ns/1ps
module nvm_program_action_control (
    input  wire logic        clock,          // 200 MHz system clock
    input  wire logic        rst,            // Synchronous reset, active high
    input  wire logic        s_axi_awvalid,  // Write address valid
    output logic             s_axi_awready,  // Write address ready
    input  wire logic [31:0] s_axi_awaddr,   // Write address
    input  wire logic [2:0]  s_axi_awprot,   // Write protection, unused
    input  wire logic        s_axi_wvalid,   // Write data valid
    output logic             s_axi_wready,   // Write data ready
    input  wire logic [31:0] s_axi_wdata,    // Write data
    input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes
    output logic             s_axi_bvalid,   // Write response valid
    input  wire logic        s_axi_bready,   // Write response ready
    output logic [1:0]       s_axi_bresp,    // Write response
    input  wire logic        s_axi_arvalid,  // Read address valid
    output logic             s_axi_arready,  // Read address ready
    input  wire logic [31:0] s_axi_araddr,   // Read address
    input  wire logic [2:0]  s_axi_arprot,   // Read protection, unused
    output logic             s_axi_rvalid,   // Read data valid
    input  wire logic        s_axi_rready,   // Read data ready
    output logic [31:0]      s_axi_rdata,    // Read data
    output logic [1:0]       s_axi_rresp,    // Read response
    input  wire logic        sleepMode,      // Memory in sleep mode
    input  wire logic [1:0]  hardreadLevel,  // Configured single hardread level
    input  wire logic        intEnable,      // Ready interrupt enable
    input  wire logic        opDone,         // Array core finished the operation
    output logic             busy,           // Sequence in progress
    output logic             readyIrq,       // One-cycle completion interrupt
    output logic             opStart,        // One-cycle launch pulse
    output logic [3:0]       operationType,  // Launched operation type
    output logic [1:0]       opVerify,       // Launched verify selection
    output logic [1:0]       hardreadSel,    // Level for array verify
    output logic [31:0]      opAddr,         // Target address
    output logic [127:0]     blockData,      // Block data for write or verify
    output logic [7:0]       blockEcc,       // Check bits of the block
    output logic             clearVerifyErr, // Clears verify_error_count
    output logic             clearEccFlags   // Clears ECC and protocol flags
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        nvm_prog_pkg::seq_state_t seq;
        logic [7:0]   action;
        logic         clrEccTrig;
        logic         clrVerrTrig;
        logic         verrEntry;
        logic [1:0]   wordCnt;
        logic [127:0] block;
        logic [31:0]  addr;
        logic [3:0]   operation_type;
        logic [1:0]   verify;
        logic         oneShot;
        logic [1:0]   level;
        logic [7:0]   ecc;
        logic         start;
        logic         irq;
        logic         awHeld;
        logic [31:0]  awAddr;
        logic         wHeld;
        logic [31:0]  wData;
        logic [3:0]   wStrb;
        logic         bValid;
        logic [1:0]   bResp;
        logic         rValid;
        logic [31:0]  rData;
        logic [1:0]   rResp;
    } ctrl_state_t;

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;
    logic [7:0]  eccNow;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Only the listed command values arm anything
    function automatic logic actionLegal(input logic [7:0] v);
        logic ok;
        ok = 1'b0;
        case (v)
            nvm_prog_pkg::ACT_WR_ONE_V,
            nvm_prog_pkg::ACT_WR_ONE,
            nvm_prog_pkg::ACT_WR_CONT_V,
            nvm_prog_pkg::ACT_WR_CONT,
            nvm_prog_pkg::ACT_ERASE_ONE,
            nvm_prog_pkg::ACT_VFY_ONE,
            nvm_prog_pkg::ACT_VFY_CONT: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic logic isCtrl(input logic [31:0] a);
        return a[31:2] == nvm_prog_pkg::PROG_CTRL_OFFSET[31:2];
    endfunction

    function automatic logic isStatus(input logic [31:0] a);
        return a[31:2] == nvm_prog_pkg::SEQ_STATUS_OFFSET[31:2];
    endfunction

    function automatic logic isMem(input logic [31:0] a);
        return a[nvm_prog_pkg::MEM_SEL_HI:nvm_prog_pkg::MEM_SEL_LO]
               == nvm_prog_pkg::MEM_SEL_VALUE;
    endfunction

    // ****************************************************************
    // Check bits of the captured block
    // ****************************************************************
    ecc_block_gen #(
        .DATA_BITS  (nvm_prog_pkg::BLOCK_W),
        .CHECK_BITS (nvm_prog_pkg::ECC_W)
    ) u_ecc (
        .data  (s_r.block),
        .check (eccNow)
    );

    // ****************************************************************
    // Bus handshakes
    // ****************************************************************
    // Memory reads wait while an operation runs; register reads wait only for a pending read response
    always_comb begin
        s_axi_awready = !s_r.awHeld;
        s_axi_wready  = !s_r.wHeld;
        s_axi_arready = !s_r.rValid &&
                        !(isMem(s_axi_araddr) && s_r.seq != nvm_prog_pkg::SEQ_IDLE);
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic        doWrite;
        logic [7:0]  newAct;
        logic [31:0] rd;
        doWrite = 1'b0;
        newAct  = 8'h00;
        rd      = 32'h0000_0000;
        s_nxt   = s_r;

        // Pulses and trigger bits last one cycle only
        s_nxt.start       = 1'b0;
        s_nxt.irq         = 1'b0;
        s_nxt.verrEntry   = 1'b0;
        s_nxt.clrEccTrig  = 1'b0;
        s_nxt.clrVerrTrig = 1'b0;

        // Address and data may arrive in either order
        if (s_axi_awvalid && !s_r.awHeld) begin
            s_nxt.awHeld = 1'b1;
            s_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.wHeld) begin
            s_nxt.wHeld = 1'b1;
            s_nxt.wData = s_axi_wdata;
            s_nxt.wStrb = s_axi_wstrb;
        end
        if (s_r.bValid && s_axi_bready) begin
            s_nxt.bValid = 1'b0;
        end
        if (s_r.rValid && s_axi_rready) begin
            s_nxt.rValid = 1'b0;
        end

        // Register reads; reserved bits stay zero
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rValid = 1'b1;
            s_nxt.rResp  = nvm_prog_pkg::RESP_OKAY;
            if (isCtrl(s_axi_araddr)) begin
                rd[7:0] = s_r.action;
                rd[nvm_prog_pkg::CLR_VERIFY_ERROR_COUNT_BIT] = s_r.clrVerrTrig;
                rd[nvm_prog_pkg::CLR_ECC_BIT]  = s_r.clrEccTrig;
            end else if (isStatus(s_axi_araddr)) begin
                rd[0]   = (s_r.seq != nvm_prog_pkg::SEQ_IDLE);
                rd[1]   = (s_r.action != nvm_prog_pkg::ACT_IDLE);
                rd[3:2] = s_r.wordCnt;
            end else if (!isMem(s_axi_araddr)) begin
                s_nxt.rResp = nvm_prog_pkg::RESP_SLVERR;
            end
            s_nxt.rData = rd;
        end

        // A write completes only when the sequencer is idle
        doWrite = s_r.awHeld && s_r.wHeld && !s_r.bValid &&
                  (s_r.seq == nvm_prog_pkg::SEQ_IDLE);
        if (doWrite) begin
            s_nxt.awHeld = 1'b0;
            s_nxt.wHeld  = 1'b0;
            s_nxt.bValid = 1'b1;
            s_nxt.bResp  = nvm_prog_pkg::RESP_OKAY;
            if (isCtrl(s_r.awAddr)) begin
                if (s_r.wStrb[0]) begin
                    if (s_r.action == nvm_prog_pkg::ACT_IDLE) begin
                        // Undefined values fall back to idle
                        newAct = actionLegal(s_r.wData[7:0]) ?
                                 s_r.wData[7:0] : nvm_prog_pkg::ACT_IDLE;
                        if (newAct[nvm_prog_pkg::OPERATION_TYPE_HI:nvm_prog_pkg::OPERATION_TYPE_LO]
                                == nvm_prog_pkg::OPERATION_TYPE_WRITE ||
                            newAct[nvm_prog_pkg::VERIFY_HI:nvm_prog_pkg::VERIFY_LO]
                                == nvm_prog_pkg::VERIFY_ARRAY) begin
                            s_nxt.verrEntry = 1'b1;
                        end
                    end else if (s_r.wData[7:0] == s_r.action) begin
                        newAct = s_r.action;
                    end else begin
                        newAct = nvm_prog_pkg::ACT_IDLE;
                    end
                    s_nxt.action  = newAct;
                    s_nxt.wordCnt = 2'h0; // Partial block is dropped on any write to the command byte
                end
                if (s_r.wStrb[1]) begin
                    s_nxt.clrEccTrig  = s_r.wData[nvm_prog_pkg::CLR_ECC_BIT];
                    s_nxt.clrVerrTrig = s_r.wData[nvm_prog_pkg::CLR_VERIFY_ERROR_COUNT_BIT];
                end
            end else if (isMem(s_r.awAddr)) begin
                if (s_r.action == nvm_prog_pkg::ACT_IDLE) begin
                    s_nxt.wordCnt = 2'h0;
                end else if (s_r.action[nvm_prog_pkg::OPERATION_TYPE_HI:nvm_prog_pkg::OPERATION_TYPE_LO]
                             == nvm_prog_pkg::OPERATION_TYPE_ERASE) begin
                    // Any word inside the page triggers the erase
                    s_nxt.addr = s_r.awAddr;
                    s_nxt.seq  = nvm_prog_pkg::SEQ_LAUNCH;
                end else begin
                    // Writes and verifies need the whole block first
                    s_nxt.block[s_r.awAddr[nvm_prog_pkg::WORD_IDX_HI:nvm_prog_pkg::WORD_IDX_LO]
                                * nvm_prog_pkg::DATA_W +: nvm_prog_pkg::DATA_W] = s_r.wData;
                    s_nxt.wordCnt = s_r.wordCnt + 2'h1;
                    if (s_r.wordCnt == 2'(nvm_prog_pkg::BLOCK_WORDS - 1)) begin
                        s_nxt.addr = {s_r.awAddr[31:4], 4'h0};
                        s_nxt.seq  = nvm_prog_pkg::SEQ_LAUNCH;
                    end
                end
            end else if (!isStatus(s_r.awAddr)) begin
                s_nxt.bResp = nvm_prog_pkg::RESP_SLVERR;
            end
        end

        // Sequencer: busy appears only once the transfer is complete
        case (s_r.seq)
            nvm_prog_pkg::SEQ_IDLE: begin
                s_nxt.seq = s_nxt.seq;
            end
            nvm_prog_pkg::SEQ_LAUNCH: begin
                s_nxt.start   = 1'b1;
                s_nxt.operation_type  = s_r.action[nvm_prog_pkg::OPERATION_TYPE_HI:nvm_prog_pkg::OPERATION_TYPE_LO];
                s_nxt.verify  = s_r.action[nvm_prog_pkg::VERIFY_HI:nvm_prog_pkg::VERIFY_LO];
                s_nxt.oneShot = s_r.action[nvm_prog_pkg::ONESHOT_HI:nvm_prog_pkg::ONESHOT_LO]
                                == nvm_prog_pkg::ONESHOT_ONCE;
                s_nxt.level   = hardreadLevel;
                s_nxt.ecc     = eccNow;
                s_nxt.seq     = nvm_prog_pkg::SEQ_RUN;
            end
            nvm_prog_pkg::SEQ_RUN: begin
                if (opDone) begin
                    s_nxt.seq = nvm_prog_pkg::SEQ_IDLE;
                    s_nxt.irq = intEnable;
                    if (s_r.oneShot) begin
                        s_nxt.action = nvm_prog_pkg::ACT_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.seq = nvm_prog_pkg::SEQ_IDLE;
            end
        endcase

        // Sleep wins over any command write in the same cycle
        if (sleepMode) begin
            s_nxt.action  = nvm_prog_pkg::ACT_IDLE;
            s_nxt.wordCnt = 2'h0;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r        <= '0;
            s_r.seq    <= nvm_prog_pkg::SEQ_IDLE;
            s_r.action <= nvm_prog_pkg::ACTION_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Auto verify uses both levels; hardreadSel matters for 11 only
    always_comb begin
        s_axi_bvalid   = s_r.bValid;
        s_axi_bresp    = s_r.bResp;
        s_axi_rvalid   = s_r.rValid;
        s_axi_rdata    = s_r.rData;
        s_axi_rresp    = s_r.rResp;
        busy           = (s_r.seq != nvm_prog_pkg::SEQ_IDLE);
        readyIrq       = s_r.irq;
        opStart        = s_r.start;
        operationType  = s_r.operation_type;
        opVerify       = s_r.verify;
        hardreadSel    = s_r.level;
        opAddr         = s_r.addr;
        blockData      = s_r.block;
        blockEcc       = s_r.ecc;
        clearVerifyErr = s_r.clrVerrTrig || s_r.verrEntry;
        clearEccFlags  = s_r.clrEccTrig;
    end

endmodule

// ==== tb/prog_ctrl_sva.sv ====
// Purpose: Port assertions for the programming sequencer
// Assumes: Bound onto nvm_program_action_control
// Notes:   runSeen_r marks the run phase
`timescale 1ns/1ps
module prog_ctrl_sva (
    input wire logic clock,          // System clock
    input wire logic rst,            // Synchronous reset
    input wire logic busy,           // Sequence in progress
    input wire logic opStart,        // Launch pulse
    input wire logic opDone,         // Core finished
    input wire logic intEnable,      // Interrupt enable
    input wire logic readyIrq,       // Completion interrupt
    input wire logic clearVerifyErr, // Verify clear pulse
    input wire logic clearEccFlags,  // Flag clear pulse
    input wire logic s_axi_bvalid,   // Write response valid
    input wire logic s_axi_bready    // Write response ready
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic runSeen_r;
    // ****************
    // Run phase: launch to done
    // ****************
    always_ff @(posedge clock) begin
        runSeen_r <= rst ? 1'b0 : (opStart | (runSeen_r & ~opDone));
    end
    start_in_busy_a: assert property (opStart |-> busy) else $error("start not busy");
    busy_then_start_a: assert property ($rose(busy) |=> opStart) else $error("no launch");
    done_irq_a: assert property (runSeen_r && opDone && intEnable |=> readyIrq && !busy)
        else $error("no irq");
    masked_irq_a: assert property (runSeen_r && opDone && !intEnable |=> !readyIrq && !busy)
        else $error("masked irq");
    irq_cause_a: assert property (readyIrq |-> $past(runSeen_r && opDone && intEnable))
        else $error("stray irq");
    busy_holds_a: assert property (runSeen_r && !opDone |=> busy) else $error("busy dropped");
    single_start_a: assert property (opStart |=> !opStart [*3]) else $error("double launch");
    verify_error_count_pulse_a: assert property (clearVerifyErr |=> !clearVerifyErr) else $error("long pulse");
    ecc_pulse_a: assert property (clearEccFlags |=> !clearEccFlags) else $error("long pulse");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("response dropped");
    cover property (opStart);
    cover property (readyIrq);
    cover property (clearEccFlags);
endmodule

// ==== tb/nvm_core_model.sv ====
// Purpose: Array core stand-in answering each launch with a done pulse
// Assumes: Launches come one at a time
// Notes:   slow adds 0..15 wait cycles
`timescale 1ns/1ps
module nvm_core_model (
    input  wire logic       clock,   // System clock
    input  wire logic       rst,     // Synchronous reset
    input  wire logic       opStart, // Launch pulse
    input  wire logic [3:0] slow,    // Extra wait cycles
    output logic            opDone   // One-cycle finish pulse
);
    logic       coreBusy_r;
    logic [4:0] delay_r;
    // ****************
    // Done never in the launch cycle
    // ****************
    always_ff @(posedge clock) begin
        opDone <= !rst && coreBusy_r && delay_r == 5'h00;
        if (rst) begin
            coreBusy_r <= 1'b0;
        end else if (opStart) begin
            coreBusy_r <= 1'b1;
            delay_r <= {1'b0, slow};
        end else if (coreBusy_r) begin
            coreBusy_r <= delay_r != 5'h00;
            delay_r <= delay_r - 5'h01;
        end
    end
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the programming sequencer
// Assumes: Array core stands in as nvm_core_model
// Notes:   bready and rready stay high
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] CTRL = nvm_prog_pkg::PROG_CTRL_OFFSET;
    logic clock = 1'b0, rst = 1'b1, sleepMode = 1'b0, intEnable = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, ta, tw, t;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic busy, readyIrq, opStart, opDone, clearVerifyErr, clearEccFlags;
    logic [1:0] s_axi_bresp, s_axi_rresp, opVerify, hardreadSel, gotHr, hardreadLevel = 2'h0;
    logic [3:0] operationType, s_axi_wstrb = 4'hF, slow = 4'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_rdata, opAddr, rdVal, base, wdat;
    logic [127:0] blockData, blk;
    logic [128:0] gotData;
    logic [37:0] gotHead;
    logic [7:0] blockEcc, cmd;
    logic [7:0] cmds[8] = '{8'h00, 8'h51, 8'h91, 8'h61, 8'hA1, 8'h92, 8'hD0, 8'hE0};
    int failures = 0, comparisons = 0, cycles = 0, starts = 0, cvCount = 0, ceCount = 0, n;
    nvm_program_action_control u_nvm_program_action_control (.*);
    nvm_core_model u_nvm_core_model (.clock(clock), .rst(rst), .opStart(opStart),
        .slow(slow), .opDone(opDone));
    always #2.5 clock = ~clock;
    // Launch capture, pulse counts, timeout
    always @(posedge clock) begin
        cycles <= cycles + 1;
        cvCount <= cvCount + int'(clearVerifyErr);
        ceCount <= ceCount + int'(clearEccFlags);
        if (opStart) begin
            starts <= starts + 1;
            gotHead <= {operationType, opVerify, opAddr};
            gotHr <= hardreadSel;
            gotData <= {blockEcc[7], blockData};
        end
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    function automatic logic [7:0] accepted(input logic [7:0] v);
        foreach (cmds[i]) if (cmds[i] == v) return v;
        return 8'h00;
    endfunction
    task automatic chk(input string nm, input logic [128:0] e, input logic [128:0] s);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    // Address and data offered together
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge clock);
            ta = s_axi_awready | !s_axi_awvalid;
            tw = s_axi_wready | !s_axi_wvalid;
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!(ta && tw));
        do begin
            @(negedge clock);
            t = s_axi_bvalid;
            rdVal = {30'h0, s_axi_bresp};
            @(posedge clock);
        end while (!t);
    endtask
    task automatic rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clock);
            t = s_axi_arready;
            @(posedge clock);
        end while (!t);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge clock);
            t = s_axi_rvalid;
            rdVal = s_axi_rdata;
            @(posedge clock);
        end while (!t);
    endtask
    task automatic wait_op(input int target);
        for (int i = 0; i < 600 && !(starts == target && busy === 1'b0); i++) @(negedge clock);
        chk("launches", target, starts);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        rdVal = $urandom(32'hCBDA0EEE);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(CTRL);
        chk("ctrl reset", 0, rdVal);
        // Every code, then random bytes
        for (int i = 0; i < 14; i++) begin
            cmd = (i < 8) ? cmds[i] : 8'($urandom);
            wdat = $urandom;
            wdat[7:0] = cmd;
            wr(CTRL, wdat);
            rd(CTRL);
            chk("ctrl cmd", {24'h0, accepted(cmd)}, rdVal);
            wr(CTRL, 0);
        end
        wr(CTRL, 32'h51);
        rd(nvm_prog_pkg::SEQ_STATUS_OFFSET);
        chk("busy on arm", 0, rdVal[0]);
        wr(CTRL, 32'h51);
        rd(CTRL);
        chk("same cmd", 32'h51, rdVal);
        wr(CTRL, 32'h91);
        rd(CTRL);
        chk("other cmd", 0, rdVal);
        wr(CTRL, 32'h61);
        sleepMode <= 1'b1;
        @(posedge clock);
        sleepMode <= 1'b0;
        rd(CTRL);
        chk("sleep", 0, rdVal);
        n = starts;
        wr(32'h0001_0040, $urandom);
        rd(CTRL);
        chk("idle trigger", n, starts);
        wr(32'h0000_0100, 0);
        chk("unmapped", 2, rdVal);
        n = cvCount;
        wr(CTRL, 32'h1000);
        rd(CTRL);
        chk("verify clear", n + 1, cvCount);
        chk("trigger read", 0, rdVal);
        n = ceCount;
        wr(CTRL, 32'h2000);
        rd(CTRL);
        chk("ecc clear", n + 1, ceCount);
        // Each command through a full run
        for (int k = 1; k < 8; k++) begin
            cmd = cmds[k];
            intEnable <= 1'($urandom);
            slow <= 4'($urandom);
            hardreadLevel <= 2'($urandom);
            base = {16'h0001, 12'($urandom), 4'h0};
            n = cvCount;
            wr(CTRL, {24'h0, cmd});
            rd(CTRL);
            chk("entry clear", n + int'(cmd[3:0] == 1 || cmd[7:6] == 3), cvCount);
            n = starts;
            // Continuous: second block waits on busy
            for (int b = 0; b < (cmd[5:4] == 2 ? 2 : 1); b++) begin
                for (int j = 3; j >= 0; j--) begin
                    blk[32*j+:32] = $urandom;
                    if (cmd[3:0] != 2 || j == 0) wr(base + 32'(4 * j), blk[32*j+:32]);
                end
                n++;
            end
            wait_op(n);
            chk("launch", {cmd[3:0], cmd[7:6], base}, gotHead);
            if (cmd[7:6] == 3) chk("level", hardreadLevel, gotHr);
            if (cmd[3:0] != 2) chk("data", {^blk, blk}, gotData);
            rd(CTRL);
            chk("after op", cmd[5:4] == 1 ? 8'h00 : cmd, rdVal);
            wr(CTRL, 0);
        end
        report_and_stop();
    end
endmodule
bind nvm_program_action_control prog_ctrl_sva u_prog_ctrl_sva (.*);
